// *** timer_pkg.sv ***
/*
  constants for the capture / auto-reload timer: register byte addresses,
  field positions, reset values, bus response codes and timing counts.
  assumes a 32-bit axi4-lite register bus and a 100 MHz system clock.
*/
package timer_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
	localparam logic [7:0] ADDR_COUNT = 8'hCC;
	localparam logic [7:0] ADDR_RELOAD_CAPTURE = 8'hD0;
	localparam logic [7:0] ADDR_INT_STATUS = 8'hD4;
	localparam logic [7:0] ADDR_INT_MASK = 8'hD8;
	localparam logic [7:0] ADDR_CONFIG = 8'hDC;
	localparam int ADDR_W = 8;
	// timer_control fields
	localparam int BIT_OVF_FLAG = 7;
	localparam int BIT_EXT_FLAG = 6;
	localparam int BIT_EXT_ENABLE = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_CT_SEL = 1;
	localparam int BIT_CAP_SEL = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_WMASK = 8'hCF;
	// config fields
	localparam int BIT_DIR_EN = 0;
	localparam int BIT_DIV_BYPASS = 1;
	localparam logic [1:0] CONFIG_RESET = 2'h0;
	// int_status / int_mask fields
	localparam int BIT_IRQ_OVF = 0;
	localparam int BIT_IRQ_EXT = 1;
	localparam logic [1:0] MASK_RESET = 2'h0;
	// counter values
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	// internal timebase divider
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 120;
	localparam int TICK_DIV = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** pin_sync.sv ***
/*
  two-flop synchroniser for one pin, with a falling edge detector behind it.
  assumes the pin is asynchronous to aclk and held at least two clocks per level.
*/
`timescale 1ns/1ps
module pin_sync
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level,
	output logic fall
);
	logic meta_r; // first stage, read only by sync_r
	logic sync_r; // second stage
	logic prev_r; // delayed copy for edge detection

	// synchroniser chain, reset to idle-high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign fall = prev_r & ~sync_r; // one-cycle pulse on high-to-low
endmodule

// *** tick_divider.sv ***
/*
  internal timebase: a one-cycle tick every DIV clocks, or every clock when bypassed.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
module tick_divider
#(
	parameter int DIV = 12
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bypass,
	output logic tick
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_r; // divider position

	// free-running divider
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_r <= '0;
		else if (cnt_r == LAST)
			cnt_r <= '0;
		else
			cnt_r <= CW'(cnt_r + 1'b1);
	end

	assign tick = bypass | (cnt_r == LAST);
endmodule

// *** capture_reload_timer.sv ***
/*
  16-bit capture / auto-reload timer with an axi4-lite register slave,
  sticky interrupt status and a level interrupt output.
  assumes the trigger and count pins are asynchronous and the bus master keeps axi rules.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module capture_reload_timer
#(
	parameter int DIV = timer_pkg::TICK_DIV
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_trigger_input,
	input wire logic external_count_input,
	output logic irq
);
	import timer_pkg::*;

	// software-visible state
	logic [7:0] timer_control_r; // flags and mode bits
	logic [1:0] config_r; // direction enable, divider bypass
	logic [15:0] count_r; // running count
	logic [15:0] reload_capture_r; // reload_capture_high:reload_capture_low
	logic [1:0] int_status_r; // sticky, cleared by read
	logic [1:0] int_mask_r; // interrupt enables
	// bus handshake state
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	// decoded control bits
	logic overflow_underflow_flag;
	logic external_event_flag;
	logic external_trigger_enable;
	logic timer_run;
	logic counter_timer_select;
	logic capture_reload_select;
	logic direction_control_enable;
	// synchronised pins and events
	logic trig_level;
	logic trig_fall;
	logic cnt_fall;
	logic base_tick;
	logic trig_act; // trigger edge that is honoured
	logic cap_evt; // capture taken
	logic rld_evt; // trigger reload taken
	logic ext_evt; // external-event flag source
	logic count_tick; // one count step
	logic count_up; // current direction
	logic ovf_evt; // overflow or underflow
	logic [15:0] wrap_value; // value after an up-count overflow
	logic [15:0] count_nxt;
	// bus decode
	logic wr_go;
	logic rd_go;
	logic wr_ok;
	logic rd_ok;
	logic [15:0] wdata16;

	// address is one of ours
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == ADDR_TIMER_CONTROL) || (a == ADDR_COUNT) || (a == ADDR_RELOAD_CAPTURE)
			|| (a == ADDR_INT_STATUS) || (a == ADDR_INT_MASK) || (a == ADDR_CONFIG);
	endfunction

	// merge write data into a 16-bit register under byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	assign overflow_underflow_flag = timer_control_r[BIT_OVF_FLAG];
	assign external_event_flag = timer_control_r[BIT_EXT_FLAG];
	assign external_trigger_enable = timer_control_r[BIT_EXT_ENABLE];
	assign timer_run = timer_control_r[BIT_RUN];
	assign counter_timer_select = timer_control_r[BIT_CT_SEL];
	assign capture_reload_select = timer_control_r[BIT_CAP_SEL];
	assign direction_control_enable = config_r[BIT_DIR_EN];

	// pin synchronisers
	pin_sync u_trig_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(external_trigger_input),
		.level(trig_level),
		.fall(trig_fall)
	);

	pin_sync u_count_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(external_count_input),
		.level(),
		.fall(cnt_fall)
	);

	// internal timebase
	tick_divider #(.DIV(DIV)) u_div
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.bypass(config_r[BIT_DIV_BYPASS]),
		.tick(base_tick)
	);

	// bus handshakes: write address and data taken together, one of each at a time
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
	assign rd_go = s_axi_arvalid & ~rvalid_r;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign wr_ok = wr_go & addr_mapped(s_axi_awaddr);
	assign rd_ok = rd_go & addr_mapped(s_axi_araddr);
	assign wdata16 = merge16(count_r, s_axi_wdata, s_axi_wstrb);

	// trigger and count event logic
	always_comb
	begin
		trig_act = external_trigger_enable & trig_fall;
		cap_evt = trig_act & capture_reload_select;
		rld_evt = trig_act & ~capture_reload_select & ~direction_control_enable;
		ext_evt = cap_evt | rld_evt;
		count_up = ~(direction_control_enable & ~trig_level);
		count_tick = timer_run & (counter_timer_select ? cnt_fall : base_tick);
		wrap_value = capture_reload_select ? COUNT_ZERO : reload_capture_r;
		ovf_evt = 1'b0;
		if (count_tick)
		begin
			if (count_up)
				ovf_evt = (count_r == COUNT_MAX);
			else if (capture_reload_select)
				ovf_evt = (count_r == COUNT_ZERO);
			else
				ovf_evt = (count_r == reload_capture_r);
		end
		// next count: trigger reload first, then counting, then software
		if (rld_evt)
			count_nxt = reload_capture_r;
		else if (count_tick)
		begin
			if (ovf_evt)
				count_nxt = count_up ? wrap_value : COUNT_MAX;
			else if (count_up)
				count_nxt = 16'(count_r + 16'h0001);
			else
				count_nxt = 16'(count_r - 16'h0001);
		end
		else if (wr_ok && s_axi_awaddr == ADDR_COUNT)
			count_nxt = wdata16;
		else
			count_nxt = count_r;
	end

	// counter register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_r <= COUNT_ZERO;
		else
			count_r <= count_nxt;
	end

	// reload / capture pair: capture beats a software write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reload_capture_r <= RELOAD_RESET;
		else if (cap_evt)
			reload_capture_r <= count_r;
		else if (wr_ok && s_axi_awaddr == ADDR_RELOAD_CAPTURE)
			reload_capture_r <= merge16(reload_capture_r, s_axi_wdata, s_axi_wstrb);
	end

	// control register: software write, then hardware flag sets win
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_control_r <= CONTROL_RESET;
		else
		begin
			if (wr_ok && s_axi_awaddr == ADDR_TIMER_CONTROL && s_axi_wstrb[0])
				timer_control_r <= s_axi_wdata[7:0] & CONTROL_WMASK;
			if (ovf_evt)
				timer_control_r[BIT_OVF_FLAG] <= 1'b1;
			if (ext_evt)
				timer_control_r[BIT_EXT_FLAG] <= 1'b1;
		end
	end

	// configuration and mask registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			config_r <= CONFIG_RESET;
			int_mask_r <= MASK_RESET;
		end
		else if (wr_ok && s_axi_wstrb[0])
		begin
			if (s_axi_awaddr == ADDR_CONFIG)
				config_r <= s_axi_wdata[1:0];
			if (s_axi_awaddr == ADDR_INT_MASK)
				int_mask_r <= s_axi_wdata[1:0];
		end
	end

	// sticky interrupt status: read clears, a new event in that cycle survives
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_status_r <= 2'h0;
		else
		begin
			if (rd_ok && s_axi_araddr == ADDR_INT_STATUS)
				int_status_r <= 2'h0;
			if (ovf_evt)
				int_status_r[BIT_IRQ_OVF] <= 1'b1;
			if (ext_evt)
				int_status_r[BIT_IRQ_EXT] <= 1'b1;
		end
	end

	assign irq = |(int_status_r & int_mask_r);

	// write response channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= addr_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	// read data channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				ADDR_TIMER_CONTROL: rdata_r <= {24'h000000, timer_control_r};
				ADDR_COUNT: rdata_r <= {16'h0000, count_r};
				ADDR_RELOAD_CAPTURE: rdata_r <= {16'h0000, reload_capture_r};
				ADDR_INT_STATUS: rdata_r <= {30'h00000000, int_status_r};
				ADDR_INT_MASK: rdata_r <= {30'h00000000, int_mask_r};
				ADDR_CONFIG: rdata_r <= {30'h00000000, config_r};
				default: rdata_r <= 32'h0000_0000; // unmapped reads as zero
			endcase
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_top_step;
		count_tick && count_up && count_r == COUNT_MAX && !rld_evt;
	endsequence
	sequence s_cap_edge;
		external_trigger_enable && capture_reload_select && trig_fall;
	endsequence

	a_ovf_up_wrap: assert property (s_top_step |=> overflow_underflow_flag)
		else $error("overflow flag not set on up wrap");
	a_reload_under: assert property (count_tick && !count_up && !capture_reload_select && !rld_evt
		&& count_r == reload_capture_r |=> overflow_underflow_flag && count_r == COUNT_MAX)
		else $error("auto-reload underflow wrong");
	a_capture_under: assert property (count_tick && !count_up && capture_reload_select
		&& count_r == COUNT_ZERO |=> overflow_underflow_flag && count_r == COUNT_MAX)
		else $error("capture underflow wrong");
	a_irq_level: assert property ((int_status_r & int_mask_r) != 2'h0 |-> irq)
		else $error("interrupt missing");
	a_irq_follows: assert property (ovf_evt && int_mask_r[BIT_IRQ_OVF]
		&& !(s_axi_awvalid && s_axi_wvalid) |=> irq)
		else $error("interrupt not raised by flag");
	a_flags_hold: assert property ($fell(overflow_underflow_flag) || $fell(external_event_flag)
		|-> $past(wr_ok) && $past(s_axi_awaddr) == ADDR_TIMER_CONTROL)
		else $error("flag cleared without software");
	// a status bit only drops after a read of int_status took it
	a_status_sticky: assert property ($fell(int_status_r[BIT_IRQ_OVF]) || $fell(int_status_r[BIT_IRQ_EXT])
		|-> $past(rd_ok) && $past(s_axi_araddr) == ADDR_INT_STATUS)
		else $error("interrupt status cleared without read");
	a_ext_flag_set: assert property (s_cap_edge |=> external_event_flag)
		else $error("external flag not set");
	a_trig_ignored: assert property (!external_trigger_enable |-> !ext_evt)
		else $error("trigger honoured while disabled");
	a_capture_copy: assert property (s_cap_edge |=> reload_capture_r == $past(count_r))
		else $error("capture value wrong");
	a_trig_reload: assert property (rld_evt |=> count_r == $past(reload_capture_r)
		&& external_event_flag)
		else $error("trigger reload wrong");
	a_dir_level: assert property (direction_control_enable && !trig_level |-> !count_up)
		else $error("direction not from trigger level");
	a_run_stop: assert property (!timer_run && !rld_evt && !(wr_ok && s_axi_awaddr == ADDR_COUNT)
		|=> $stable(count_r))
		else $error("count moved while stopped");
	a_ext_count: assert property (timer_run && counter_timer_select && !cnt_fall |-> !count_tick)
		else $error("counter mode counted without pin edge");
	a_mode_sel: assert property (trig_act && !capture_reload_select |-> !cap_evt)
		else $error("capture in auto-reload mode");
endmodule

// *** trigger_pin_model.sv ***
/*
  model of the external trigger and count pins driven by outside logic.
  assumes one request pulse per event and waits of at least 10 clocks between events.
*/
`timescale 1ns/1ps
module trigger_pin_model
(
	input wire logic aclk,
	input wire logic trig_req,
	input wire logic cnt_req,
	input wire logic trig_hold,
	output logic trig_pin,
	output logic cnt_pin
);
	logic [3:0] tc_r = 4'h0; // trigger pulse timer
	logic [3:0] cc_r = 4'h0; // count pulse timer
	// each request starts a pulse; the pin stays low for 4 clocks
	always @(posedge aclk)
	begin
		tc_r <= trig_req ? 4'h8 : (tc_r != 4'h0 ? tc_r - 4'h1 : 4'h0);
		cc_r <= cnt_req ? 4'h8 : (cc_r != 4'h0 ? cc_r - 4'h1 : 4'h0);
	end
	// pins idle high; a held trigger gives a steady low level
	assign trig_pin = !(trig_hold || tc_r > 4'h4);
	assign cnt_pin = !(cc_r > 4'h4);
endmodule

// *** capture_reload_timer_control_test.sv ***
/*
  self-checking bench for the capture / auto-reload timer.
  assumes the axi slave answers in its own time and the pins come from trigger_pin_model.
*/
`timescale 1ns/1ps
module capture_reload_timer_control_test;
	import timer_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, d, rv;
	logic [15:0] r16;
	logic treq = 1'b0, creq = 1'b0, hold = 1'b0, tpin, cpin;
	int fails = 0;
	int num_checks = 0;
	int seed = 32'h65e0f5a7;
	capture_reload_timer #(.DIV(12)) uut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_trigger_input(tpin), .external_count_input(cpin), .irq(irq)
	);
	trigger_pin_model pins
	(
		.aclk(aclk), .trig_req(treq), .cnt_req(creq), .trig_hold(hold), .trig_pin(tpin), .cnt_pin(cpin)
	);
	// 100 MHz clock
	initial
	begin
		forever #5 aclk = ~aclk;
	end
	// compare and count
	task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// verdict
	task end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// axi write: address and data offered together, held until taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	// axi read: data and response land in d and rsp
	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	// one pulse on a pin, then room for sync and action
	task pulse(input bit cnt);
		@(posedge aclk);
		if (cnt)
			creq <= 1'b1;
		else
			treq <= 1'b1;
		@(posedge aclk);
		creq <= 1'b0;
		treq <= 1'b0;
		repeat (12) @(posedge aclk);
	endtask
	// watchdog
	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		end_sim();
	end
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_TIMER_CONTROL);
		check("control reset", d, 32'h0);
		check("control rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
		rd(8'hE0);
		check("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		check("unmapped rdata", d, 32'h0);
		// a write to a hole is refused with an error response
		wr(8'hE0, 32'hFF);
		check("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		// stopped timer holds its count
		r16 = 16'($random(seed));
		wr(ADDR_CONFIG, 32'h2);
		check("config bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
		wr(ADDR_COUNT, {16'h0, r16});
		wr(ADDR_TIMER_CONTROL, 32'h01);
		repeat (20) @(posedge aclk);
		rd(ADDR_COUNT);
		check("stopped count", d, {16'h0, r16});
		// up-count wrap, interrupt, sticky flag
		wr(ADDR_INT_MASK, 32'h3);
		wr(ADDR_COUNT, 32'hFFF0);
		wr(ADDR_TIMER_CONTROL, 32'h05);
		repeat (40) @(posedge aclk);
		rd(ADDR_TIMER_CONTROL);
		check("wrap flag", d & 32'h80, 32'h80);
		check("irq high", {31'h0, irq}, 32'h1);
		rd(ADDR_INT_STATUS);
		check("status ovf", d & 32'h1, 32'h1);
		repeat (50) @(posedge aclk);
		rd(ADDR_TIMER_CONTROL);
		check("flag kept", d & 32'hC0, 32'h80);
		wr(ADDR_TIMER_CONTROL, 32'h01);
		rd(ADDR_TIMER_CONTROL);
		check("flag cleared", d, 32'h01);
		// trigger ignored while external enable is off
		r16 = 16'($random(seed));
		wr(ADDR_COUNT, {16'h0, r16});
		wr(ADDR_RELOAD_CAPTURE, 32'h0);
		pulse(1'b0);
		rd(ADDR_RELOAD_CAPTURE);
		check("no capture", d, 32'h0);
		rd(ADDR_TIMER_CONTROL);
		check("no ext flag", d, 32'h01);
		// capture on trigger fall
		wr(ADDR_TIMER_CONTROL, 32'h09);
		pulse(1'b0);
		rd(ADDR_RELOAD_CAPTURE);
		check("captured", d, {16'h0, r16});
		rd(ADDR_TIMER_CONTROL);
		check("ext flag cap", d, 32'h49);
		rd(ADDR_INT_STATUS);
		check("status ext", d & 32'h2, 32'h2);
		// reload on trigger fall in auto-reload mode
		rv = $random(seed);
		wr(ADDR_RELOAD_CAPTURE, {16'h0, rv[15:0]});
		wr(ADDR_COUNT, 32'h0123);
		wr(ADDR_TIMER_CONTROL, 32'h08);
		pulse(1'b0);
		rd(ADDR_COUNT);
		check("reloaded", d, {16'h0, rv[15:0]});
		rd(ADDR_TIMER_CONTROL);
		check("ext flag rld", d, 32'h48);
		// capture mode down-count underflow from zero
		wr(ADDR_CONFIG, 32'h3);
		hold <= 1'b1;
		wr(ADDR_COUNT, 32'h0003);
		wr(ADDR_TIMER_CONTROL, 32'h05);
		repeat (30) @(posedge aclk);
		rd(ADDR_TIMER_CONTROL);
		check("capture underflow", d & 32'h80, 32'h80);
		// auto-reload down-count passing the reload value
		r16 = {4'h1, rv[27:16]};
		wr(ADDR_TIMER_CONTROL, 32'h00);
		wr(ADDR_RELOAD_CAPTURE, {16'h0, r16});
		wr(ADDR_COUNT, {16'h0, r16 + 16'h5});
		wr(ADDR_TIMER_CONTROL, 32'h04);
		repeat (30) @(posedge aclk);
		rd(ADDR_TIMER_CONTROL);
		check("reload underflow", d & 32'h80, 32'h80);
		wr(ADDR_TIMER_CONTROL, 32'h00);
		rd(ADDR_COUNT);
		check("down from top", {31'h0, d[15:0] > r16}, 32'h1);
		// counter function counts pin falls only
		hold <= 1'b0;
		wr(ADDR_CONFIG, 32'h2);
		wr(ADDR_COUNT, 32'h0010);
		wr(ADDR_TIMER_CONTROL, 32'h06);
		repeat (5) pulse(1'b1);
		rd(ADDR_COUNT);
		check("pin count", d, 32'h0015);
		end_sim();
	end
endmodule
